// ### hdl/aas_pkg.sv
// Constants, register map and state codes of the averaging acquisition strobe timer
// Assumes one 125 MHz clock; every programmable interval is counted in 1 us ticks
// Notes on behaviour
// - Variant A busy 3706 us each, no gap
// - Variant A integration 3800 us to 10 s
// - Variant B busy 15 ns, 835 gap, 4977
// - Single pulse timed in us, low after integration one
// - Periodic strobe runs only when period below integration
// - Tail after last full period is under one period
// - Each strobe has its own enable
// - Integration count from 2 to 65535
// - Only software and edge trigger accepted
// - Acquisition delay up to 335500 us, length unchanged
package aas_pkg;
  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int US_NS = 1000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  localparam int TCW = 7;
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYC - 1);
  // ----------------------------------------
  // Widths and register map
  // ----------------------------------------
  localparam int TW = 24;
  localparam int NW = 16;
  localparam int AW = 8;
  typedef logic [TW-1:0] aas_time_t;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_ACQ_DELAY = 8'h04;
  localparam logic [AW-1:0] OFS_INTEG = 8'h08;
  localparam logic [AW-1:0] OFS_COUNT = 8'h0c;
  localparam logic [AW-1:0] OFS_SS_DELAY = 8'h10;
  localparam logic [AW-1:0] OFS_SS_WIDTH = 8'h14;
  localparam logic [AW-1:0] OFS_CS_PERIOD = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS = 8'h1c;
  localparam int CB_START = 0;
  localparam int CB_EDGE = 1;
  localparam int CB_SS_EN = 2;
  localparam int CB_CS_EN = 3;
  localparam int SB_FIRST = 3;
  localparam int SB_IDX = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Limits and variant constants, in us except BUSY1_B_NS (ns), BUSY1_B_CYC (clocks) and COUNT_MIN
  // ----------------------------------------
  localparam aas_time_t ACQ_DLY_MAX_US = 24'h051e8c;
  localparam aas_time_t INTEG_MIN_A_US = 24'h000ed8;
  localparam aas_time_t INTEG_MAX_A_US = 24'h989680;
  localparam aas_time_t INTEG_MIN_B_US = 24'h001c20;
  localparam aas_time_t INTEG_MAX_B_US = 24'h4c4b40;
  localparam aas_time_t BUSY1_A_US = 24'h000e7a;
  localparam aas_time_t GAP_A_US = 24'h000000;
  localparam aas_time_t BUSY3_A_US = 24'h000e7a;
  localparam int BUSY1_B_NS = 15;
  localparam aas_time_t BUSY1_B_CYC = TW'((BUSY1_B_NS * CLK_MHZ + US_NS - 1) / US_NS);
  localparam aas_time_t GAP_B_US = 24'h000343;
  localparam aas_time_t BUSY3_B_US = 24'h001371;
  localparam logic [NW-1:0] COUNT_MIN = 16'h0002;
  localparam aas_time_t INTEG_RST = 24'h001c20;
  // ----------------------------------------
  // Sequencer states, Gray from ST_IDLE through ST_DELAY, ST_BUSY1, ST_INTEG and ST_GAP
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_BUSY1 = 3'h3,
    ST_INTEG = 3'h2,
    ST_GAP = 3'h6,
    ST_BUSY3 = 3'h7
  } aas_state_t;

  function automatic logic in_range(aas_time_t v, aas_time_t lo, aas_time_t hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      wmerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// ### hdl/aas_us_tick.sv
// Microsecond tick generator for the acquisition timer
// Assumes aclk at the package rate; hold keeps the prescaler cleared
`timescale 1ns/1ps
`default_nettype none
module aas_us_tick
  import aas_pkg::*;
#(
  parameter int DIV = TICK_CYC
)
(
  input wire logic aclk,     // Clock
  input wire logic aresetn,  // Sync reset, low
  input wire logic hold,     // Clear prescaler
  output logic tick          // One-cycle pulse each us
);
  import aas_pkg::*;
  localparam logic [TCW-1:0] DIV_LAST = TCW'(DIV - 1);
  logic [TCW-1:0] div_reg;
  logic [TCW-1:0] gap_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold)
      div_reg <= '0;
    else if (div_reg == DIV_LAST)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  assign tick = !hold && (div_reg == DIV_LAST);

  // Independent count of cycles between ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold || tick)
      gap_reg <= '0;
    else
      gap_reg <= gap_reg + 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tick_spacing: assert property (tick |-> gap_reg == DIV_LAST)
    else $error("tick spacing wrong");
endmodule
`default_nettype wire

// ### hdl/aas_timer.sv
// Averaging acquisition sequencer with single and periodic strobes
// Assumes an AXI4-Lite master on aclk and an asynchronous trigger pin
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aas_timer
  import aas_pkg::*;
#(
  parameter bit VARIANT_B = 1'b0,
  parameter int TICK_DIV = TICK_CYC  // Clocks per microsecond tick
)
(
  input wire logic aclk,                 // Clock
  input wire logic aresetn,              // Sync reset, low
  input wire logic [aas_pkg::AW-1:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,        // Write address valid
  output logic s_axi_awready,            // Write address ready
  input wire logic [31:0] s_axi_wdata,   // Write data
  input wire logic [3:0] s_axi_wstrb,    // Byte enables
  input wire logic s_axi_wvalid,         // Write data valid
  output logic s_axi_wready,             // Write data ready
  output logic [1:0] s_axi_bresp,        // Write response
  output logic s_axi_bvalid,             // Write response valid
  input wire logic s_axi_bready,         // Write response ready
  input wire logic [aas_pkg::AW-1:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,        // Read address valid
  output logic s_axi_arready,            // Read address ready
  output logic [31:0] s_axi_rdata,       // Read data
  output logic [1:0] s_axi_rresp,        // Read response
  output logic s_axi_rvalid,             // Read data valid
  input wire logic s_axi_rready,         // Read data ready
  input wire logic ext_trigger,          // External edge trigger pin
  output logic single_strobe,            // Single pulse output
  output logic periodic_strobe,          // Periodic strobe output
  output logic integrating               // High during integration
);
  import aas_pkg::*;

  localparam aas_time_t INTEG_MIN = VARIANT_B ? INTEG_MIN_B_US : INTEG_MIN_A_US;
  localparam aas_time_t INTEG_MAX = VARIANT_B ? INTEG_MAX_B_US : INTEG_MAX_A_US;
  localparam aas_time_t BUSY1_LIM = VARIANT_B ? BUSY1_B_CYC : BUSY1_A_US;
  localparam aas_time_t GAP_LIM = VARIANT_B ? GAP_B_US : GAP_A_US;
  localparam aas_time_t BUSY3_LIM = VARIANT_B ? BUSY3_B_US : BUSY3_A_US;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic edge_en_reg, ss_en_reg, cs_en_reg, start_reg;
  aas_time_t acq_reg, integ_reg, ssd_reg, ssw_reg, csp_reg;
  logic [NW-1:0] count_reg, idx_reg;
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg, wv;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_wr;
  aas_state_t state_reg, state_next;
  aas_time_t cnt_reg, ss_cnt_reg, ph_reg, lim;
  logic first_done_reg, cs_act_reg, ss_reg, cs_reg;
  logic tick, step, last, trig, more, enter_integ, end_first, cs_ok;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_rise;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg > OFS_CS_PERIOD || awaddr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Register update; out-of-range values are dropped, upper bits checked for delay and integration only
  always_comb
  begin
    wv = '0;
    unique case (awaddr_reg)
      OFS_CTRL: wv = wmerge({28'h0, cs_en_reg, ss_en_reg, edge_en_reg, 1'b0}, wdata_reg, wstrb_reg);
      OFS_ACQ_DELAY: wv = wmerge({8'h0, acq_reg}, wdata_reg, wstrb_reg);
      OFS_INTEG: wv = wmerge({8'h0, integ_reg}, wdata_reg, wstrb_reg);
      OFS_COUNT: wv = wmerge({16'h0, count_reg}, wdata_reg, wstrb_reg);
      OFS_SS_DELAY: wv = wmerge({8'h0, ssd_reg}, wdata_reg, wstrb_reg);
      OFS_SS_WIDTH: wv = wmerge({8'h0, ssw_reg}, wdata_reg, wstrb_reg);
      OFS_CS_PERIOD: wv = wmerge({8'h0, csp_reg}, wdata_reg, wstrb_reg);
      default: wv = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {edge_en_reg, ss_en_reg, cs_en_reg, start_reg} <= 4'h0;
      acq_reg <= '0;
      integ_reg <= INTEG_RST;
      count_reg <= COUNT_MIN;
      ssd_reg <= '0;
      ssw_reg <= '0;
      csp_reg <= '0;
    end
    else
    begin
      start_reg <= do_wr && awaddr_reg == OFS_CTRL && wv[CB_START];
      if (do_wr)
      begin
        unique case (awaddr_reg)
          OFS_CTRL:
          begin
            edge_en_reg <= wv[CB_EDGE];
            ss_en_reg <= wv[CB_SS_EN];
            cs_en_reg <= wv[CB_CS_EN];
          end
          OFS_ACQ_DELAY: if (wv[31:TW] == 8'h0 && wv[TW-1:0] <= ACQ_DLY_MAX_US) acq_reg <= wv[TW-1:0];
          OFS_INTEG: if (wv[31:TW] == 8'h0 && in_range(wv[TW-1:0], INTEG_MIN, INTEG_MAX)) integ_reg <= wv[TW-1:0];
          OFS_COUNT: if (wv[NW-1:0] >= COUNT_MIN) count_reg <= wv[NW-1:0];
          OFS_SS_DELAY: ssd_reg <= wv[TW-1:0];
          OFS_SS_WIDTH: ssw_reg <= wv[TW-1:0];
          OFS_CS_PERIOD: if (wv[TW-1:0] <= integ_reg) csp_reg <= wv[TW-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_reg <= {28'h0, cs_en_reg, ss_en_reg, edge_en_reg, 1'b0};
        OFS_ACQ_DELAY: rdata_reg <= {8'h0, acq_reg};
        OFS_INTEG: rdata_reg <= {8'h0, integ_reg};
        OFS_COUNT: rdata_reg <= {16'h0, count_reg};
        OFS_SS_DELAY: rdata_reg <= {8'h0, ssd_reg};
        OFS_SS_WIDTH: rdata_reg <= {8'h0, ssw_reg};
        OFS_CS_PERIOD: rdata_reg <= {8'h0, csp_reg};
        OFS_STATUS: rdata_reg <= {idx_reg, 12'h0, first_done_reg, state_reg};
        default:
        begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------
  // Trigger and timebase
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {ext_s1_reg, ext_s2_reg, ext_s3_reg} <= 3'h0;
    else
      {ext_s1_reg, ext_s2_reg, ext_s3_reg} <= {ext_trigger, ext_s1_reg, ext_s2_reg};
  end

  assign ext_rise = ext_s2_reg && !ext_s3_reg;
  assign trig = start_reg || (edge_en_reg && ext_rise);

  aas_us_tick #(.DIV(TICK_DIV)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(state_reg == ST_IDLE),
    .tick(tick)
  );

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  always_comb
  begin
    unique case (state_reg)
      ST_DELAY: lim = acq_reg;
      ST_BUSY1: lim = BUSY1_LIM;
      ST_INTEG: lim = integ_reg;
      ST_GAP: lim = GAP_LIM;
      ST_BUSY3: lim = BUSY3_LIM;
      default: lim = '0;
    endcase
  end

  assign step = (VARIANT_B && state_reg == ST_BUSY1) ? 1'b1 : tick;
  assign last = step && (cnt_reg == lim - 1'b1);
  assign more = idx_reg != count_reg - 1'b1;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (trig) state_next = (acq_reg == '0) ? ST_BUSY1 : ST_DELAY;
      ST_DELAY: if (last) state_next = ST_BUSY1;
      ST_BUSY1: if (last) state_next = ST_INTEG;
      ST_INTEG: if (last) state_next = !more ? ST_BUSY3 : (GAP_LIM == '0) ? ST_INTEG : ST_GAP;
      ST_GAP: if (last) state_next = ST_INTEG;
      ST_BUSY3: if (last) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  assign enter_integ = state_next == ST_INTEG && (state_reg != ST_INTEG || last);
  assign end_first = state_reg == ST_INTEG && last && !first_done_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      idx_reg <= '0;
      first_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg || last) ? '0 : cnt_reg + TW'(step);
      if (state_reg == ST_IDLE)
      begin
        idx_reg <= '0;
        if (trig)
          first_done_reg <= 1'b0;
      end
      else if (state_reg == ST_INTEG && last)
      begin
        first_done_reg <= 1'b1;
        if (more)
          idx_reg <= idx_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Strobes
  // ----------------------------------------
  assign cs_ok = cs_en_reg && csp_reg != '0 && csp_reg < integ_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_reg == ST_IDLE)
      ss_cnt_reg <= '0;
    else if (tick && ss_cnt_reg != '1)
      ss_cnt_reg <= ss_cnt_reg + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || enter_integ)
    begin
      ph_reg <= '0;
      cs_act_reg <= aresetn && cs_ok;
    end
    else if (state_reg != ST_INTEG)
      cs_act_reg <= 1'b0;
    else if (tick)
    begin
      ph_reg <= (ph_reg == csp_reg - 1'b1) ? '0 : ph_reg + 1'b1;
      // Start a period only if it ends inside integration
      if (ph_reg == csp_reg - 1'b1)
        cs_act_reg <= cs_ok && (integ_reg - cnt_reg - 1'b1) >= csp_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ss_reg <= 1'b0;
      cs_reg <= 1'b0;
    end
    else
    begin
      ss_reg <= ss_en_reg && state_reg != ST_IDLE && !first_done_reg && !end_first
        && ss_cnt_reg >= ssd_reg && {1'b0, ss_cnt_reg} < {1'b0, ssd_reg} + {1'b0, ssw_reg};
      cs_reg <= cs_en_reg && state_reg == ST_INTEG && !last && cs_act_reg
        && ph_reg < ((csp_reg + 1'b1) >> 1);
    end
  end

  assign single_strobe = ss_reg;
  assign periodic_strobe = cs_reg;
  assign integrating = state_reg == ST_INTEG;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_trig_idle;
    state_reg == ST_IDLE && trig;
  endsequence
  a_delay_first: assert property (s_trig_idle ##0 acq_reg != '0 |=> state_reg == ST_DELAY)
    else $error("delay not entered after trigger");
  a_no_spurious: assert property (state_reg == ST_IDLE && !trig |=> state_reg == ST_IDLE)
    else $error("cycle started without trigger");
  a_gap_zero: assert property (!VARIANT_B && state_reg == ST_INTEG && last && more
    |=> state_reg == ST_INTEG && cnt_reg == '0)
    else $error("integrations not back to back");
  a_gap_b: assert property (VARIANT_B && state_reg == ST_INTEG && last && more |=> state_reg == ST_GAP)
    else $error("gap missing");
  a_integ_range: assert property (in_range(integ_reg, INTEG_MIN, INTEG_MAX))
    else $error("integration period out of range");
  a_ss_first: assert property (first_done_reg |=> !single_strobe)
    else $error("single pulse after first integration");
  a_cs_short: assert property (periodic_strobe |-> csp_reg < integ_reg)
    else $error("periodic strobe with long period");
  a_cs_integ: assert property (periodic_strobe |-> $past(state_reg) == ST_INTEG)
    else $error("periodic strobe outside integration");
  a_strobe_off: assert property (!ss_en_reg && !cs_en_reg |=> !single_strobe && !periodic_strobe)
    else $error("disabled strobe active");
  a_count_min: assert property (count_reg >= COUNT_MIN)
    else $error("integration count below two");
endmodule
`default_nettype wire

// ### bench/aas_far_end.sv
// Far-end model: edge trigger source and strobe watcher
// Assumes the timer's pins, sampled on the same aclk
`timescale 1ns/1ps
`default_nettype none
module aas_far_end (
  input wire logic aclk,             // Clock
  input wire logic fire,             // Request one trigger pulse
  input wire logic clr,              // Clear event counters
  input wire logic single_strobe,    // Watched single strobe
  input wire logic periodic_strobe,  // Watched periodic strobe
  input wire logic integrating,      // Watched integration phase
  output logic ext_trigger,          // Edge trigger pin
  output int trig_at,                // Cycle of last trigger rise
  output int ss_rise,                // Cycle of last single rise
  output int ss_fall,                // Cycle of last single fall
  output int in_rise,                // Cycle of last integration rise
  output int in_fall,                // Cycle of last integration fall
  output int ss_n,                   // Single strobe pulses
  output int in_n,                   // Integration rises
  output int cs_n,                   // Periodic strobe rises
  output int stray                   // Periodic high outside integration
);
  int cyc = 0;
  int hold = 0;
  logic ss_d = 1'b0;
  logic cs_d = 1'b0;
  logic in_d = 1'b0;
  // ----------------------------------------
  // Trigger pulse and event log
  // ----------------------------------------
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    ss_d <= single_strobe;
    cs_d <= periodic_strobe;
    in_d <= integrating;
    hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
    ext_trigger <= fire || hold > 1;  // Short edge pulse, never a level
    if (fire) trig_at <= cyc;
    if (single_strobe && !ss_d) ss_rise <= cyc;
    if (!single_strobe && ss_d) ss_fall <= cyc;
    if (integrating && !in_d) in_rise <= cyc;
    if (!integrating && in_d) in_fall <= cyc;
    if (clr)
      {ss_n, in_n, cs_n, stray} <= '0;
    else
    begin
      if (single_strobe && !ss_d) ss_n <= ss_n + 1;
      if (integrating && !in_d) in_n <= in_n + 1;
      if (periodic_strobe && !cs_d) cs_n <= cs_n + 1;
      if (periodic_strobe && !in_d) stray <= stray + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/aas_timer_test.sv
// Testbench of the acquisition timer: registers, cycle timing, strobes
// Assumes variant A with a shortened microsecond tick to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module aas_timer_test;
  import aas_pkg::*;
  typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} aas_exp_t;
  // Clocks per microsecond tick in this bench
  localparam int US = 2;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, fire, clr;
  logic ext_trigger, single_strobe, periodic_strobe, integrating;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int trig_at, ss_rise, ss_fall, in_rise, in_fall, ss_n, in_n, cs_n, stray;
  int errors = 0;
  int n_checks = 0;
  int acq;
  logic [31:0] seed = 32'h00008716;
  logic [31:0] rst_v [8] = '{32'h0, 32'h0, 32'h1c20, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
  aas_exp_t bq[$];
  aas_exp_t rq[$];
  aas_exp_t e;

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  aas_timer #(.VARIANT_B(1'b0), .TICK_DIV(US)) i_aas_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger(ext_trigger), .single_strobe(single_strobe),
    .periodic_strobe(periodic_strobe), .integrating(integrating));
  aas_far_end i_aas_far_end (.aclk(aclk), .fire(fire), .clr(clr), .single_strobe(single_strobe),
    .periodic_strobe(periodic_strobe), .integrating(integrating), .ext_trigger(ext_trigger),
    .trig_at(trig_at), .ss_rise(ss_rise), .ss_fall(ss_fall), .in_rise(in_rise),
    .in_fall(in_fall), .ss_n(ss_n), .in_n(in_n), .cs_n(cs_n), .stray(stray));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_checks++;
    if (g !== x) fail($sformatf("%s got %0h exp %0h", m, g, x));
  endtask
  task automatic near(input int g, input int x, input int tol, input string m);
    n_checks++;
    if (g < x - tol || g > x + tol) fail($sformatf("%s got %0d exp %0d", m, g, x));
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    bq.push_back('{r, 32'h0, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 100)
    begin
      fail("write hang");
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int k;
    rq.push_back('{RESP_OKAY, d & m, m});
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 100)
    begin
      fail("read hang");
      end_sim();
    end
  endtask
  task automatic wait_in(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && integrating !== v; k++) @(posedge aclk);
    if (k == lim)
    begin
      fail("phase hang");
      end_sim();
    end
  endtask
  task automatic pulse_clr();
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Response monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (bvalid && bready && bq.size() > 0)
    begin
      e = bq.pop_front();
      chk(bresp, e.resp, "bresp");
    end
    if (rvalid && rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk(rresp, e.resp, "rresp");
      chk(rdata & e.mask, e.data, "rdata");
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {awvalid, wvalid, arvalid, fire, awaddr, araddr, wdata} = '0;
    aresetn = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    clr = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    clr <= 1'b0;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), rst_v[i], 32'hffffffff);
    acq = int'(rnd() % (ACQ_DLY_MAX_US + 1));
    wr(OFS_ACQ_DELAY, 32'(acq), RESP_OKAY);
    wr(OFS_ACQ_DELAY, 32'(ACQ_DLY_MAX_US) + 32'h1, RESP_OKAY);
    rd(OFS_ACQ_DELAY, 32'(acq), 32'hffffffff);
    wr(OFS_INTEG, 32'(INTEG_MIN_A_US) - 32'h1, RESP_OKAY);
    rd(OFS_INTEG, 32'h1c20, 32'hffffffff);
    wr(OFS_INTEG, 32'(INTEG_MAX_A_US), RESP_OKAY);
    wr(OFS_INTEG, 32'(INTEG_MAX_A_US) + 32'h1, RESP_OKAY);
    rd(OFS_INTEG, 32'(INTEG_MAX_A_US), 32'hffffffff);
    wr(OFS_CS_PERIOD, 32'(INTEG_MAX_A_US) + 32'h1, RESP_OKAY);
    rd(OFS_CS_PERIOD, 32'h0, 32'hffffffff);
    wr(OFS_COUNT, 32'h1, RESP_OKAY);
    rd(OFS_COUNT, 32'h2, 32'hffffffff);
    wr(OFS_COUNT, 32'hffff, RESP_OKAY);
    rd(OFS_COUNT, 32'hffff, 32'hffffffff);
    wr(8'h20, rnd(), RESP_SLVERR);
    wr(OFS_STATUS, rnd(), RESP_SLVERR);
    $display("Test registers done");
    // Full cycle, software trigger, single strobe cut by integration end
    wr(OFS_ACQ_DELAY, 32'h5, RESP_OKAY);
    wr(OFS_INTEG, 32'(INTEG_MIN_A_US), RESP_OKAY);
    wr(OFS_COUNT, 32'h2, RESP_OKAY);
    wr(OFS_SS_DELAY, 32'h3, RESP_OKAY);
    wr(OFS_SS_WIDTH, 32'h4e20, RESP_OKAY);
    wr(OFS_CS_PERIOD, 32'h3e8, RESP_OKAY);
    pulse_clr();
    wr(OFS_CTRL, 32'hd, RESP_OKAY);
    wait_in(1'b1, 4000 * US);
    wait_in(1'b0, 7700 * US);
    repeat (3706 * US - 20) @(posedge aclk);
    rd(OFS_STATUS, 32'h7, 32'h7);
    repeat (30) @(posedge aclk);
    rd(OFS_STATUS, 32'h0, 32'h7);
    near(in_rise - ss_rise, (5 + 3706 - 3) * US, 2, "strobe to integration");
    near(ss_fall - in_rise, 3800 * US, 2, "strobe cut");
    near(in_fall - in_rise, 2 * 3800 * US, 2, "integration span");
    chk(32'(in_n), 32'h1, "integration runs");
    chk(32'(cs_n), 32'h6, "periodic pulses");
    chk(32'(stray), 32'h0, "periodic outside");
    $display("Test full cycle done");
    // Edge trigger, random delay, single disabled, periodic enabled
    acq = int'(rnd() % 32'h28);
    wr(OFS_ACQ_DELAY, 32'(acq), RESP_OKAY);
    wr(OFS_SS_DELAY, 32'h0, RESP_OKAY);
    wr(OFS_SS_WIDTH, 32'ha, RESP_OKAY);
    wr(OFS_CS_PERIOD, 32'h64, RESP_OKAY);
    wr(OFS_CTRL, 32'ha, RESP_OKAY);
    pulse_clr();
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wait_in(1'b1, 4000 * US);
    repeat (250 * US) @(posedge aclk);
    near(in_rise - trig_at, (acq + int'(BUSY1_A_US)) * US, 6, "trigger to integration");
    chk(32'(ss_n), 32'h0, "single disabled");
    chk(32'(cs_n), 32'h3, "periodic enabled");
    do_reset();
    $display("Test edge trigger done");
    // Period equal to integration, zero single width
    wr(OFS_CS_PERIOD, 32'h1c20, RESP_OKAY);
    pulse_clr();
    wr(OFS_CTRL, 32'hd, RESP_OKAY);
    wait_in(1'b1, 4000 * US);
    repeat (100 * US) @(posedge aclk);
    chk(32'(cs_n), 32'h0, "periodic idle");
    chk(32'(ss_n), 32'h0, "single zero width");
    do_reset();
    $display("Test strobe limits done");
    end_sim();
  end
endmodule
`default_nettype wire
